//--- goc_pkg.sv
package goc_pkg;

	// Byte addresses of the register pairs (low byte address)
	localparam logic [6:0] ADDR_AUX_DAC_LEVEL    = 7'h30;
	localparam logic [6:0] ADDR_IO_LINE_CONTROL  = 7'h32;
	localparam logic [6:0] ADDR_SAMPLE_PERIOD    = 7'h36;
	localparam logic [6:0] ADDR_RANGE_AND_FILTER = 7'h38;
	localparam logic [6:0] ADDR_SLEEP_COUNT      = 7'h3A;
	localparam logic [6:0] ADDR_COMMAND          = 7'h3E;

	// Reset values
	localparam logic [15:0] RST_AUX_DAC_LEVEL    = 16'h0000;
	localparam logic [15:0] RST_IO_LINE_CONTROL  = 16'h0000;
	localparam logic [15:0] RST_SAMPLE_PERIOD    = 16'h0001;
	localparam logic [15:0] RST_RANGE_AND_FILTER = 16'h0402;
	localparam logic [15:0] RST_SLEEP_COUNT      = 16'h0000;

	// Writable bit masks
	localparam logic [15:0] MASK_AUX_DAC_LEVEL    = 16'h0FFF;
	localparam logic [15:0] MASK_IO_LINE_CONTROL  = 16'h0303;
	localparam logic [15:0] MASK_SAMPLE_PERIOD    = 16'h00FF;
	localparam logic [15:0] MASK_RANGE_AND_FILTER = 16'h070F;
	localparam logic [15:0] MASK_SLEEP_COUNT      = 16'h00FF;

	// Field positions
	localparam int SP_TIME_BASE_BIT   = 7;
	localparam int CMD_DAC_LATCH_BIT  = 2;
	localparam int IO_LEVEL_LSB       = 8;

	// Range selection patterns and minimum tap exponents
	localparam logic [2:0] RANGE_80 = 3'h4;
	localparam logic [2:0] RANGE_40 = 3'h2;
	localparam logic [2:0] RANGE_20 = 3'h1;
	localparam logic [3:0] MIN_TAPS_40 = 4'h2;
	localparam logic [3:0] MIN_TAPS_20 = 4'h4;
	localparam logic [3:0] MAX_TAP_EXP = 4'h7;

	// Times and derived cycle counts at 250 MHz
	localparam real CLK_MHZ       = 250.0;
	localparam real TB_SHORT_US   = 1953.0;
	localparam real TB_LONG_US    = 60540.0;
	localparam real SLEEP_UNIT_MS = 500.0;
	localparam int  TB_SHORT_CYC  = int'($floor(TB_SHORT_US * CLK_MHZ));
	localparam int  TB_LONG_CYC   = int'($floor(TB_LONG_US * CLK_MHZ));
	localparam int  SLEEP_UNIT_CYC = int'($floor(SLEEP_UNIT_MS * 1000.0 * CLK_MHZ));

	// Low-power threshold: periods longer than 64 SPS (15.624 ms)
	localparam real LOW_RATE_PERIOD_US = 15624.0;

	localparam int SYNC_STAGES = 3;

	typedef enum logic [1:0] {
		GOC_IDLE,
		GOC_ADDR,
		GOC_DATA
	} goc_spi_state_e;

	typedef enum logic {
		GOC_RUN,
		GOC_SLEEP
	} goc_power_state_e;

endpackage

//--- goc_sync.sv
`timescale 1ns/1ps
module goc_sync
	import goc_pkg::*;
#(
	parameter logic RESET_VALUE = 1'b0
)(
	input  wire logic clock,
	input  wire logic rst_b,
	input  wire logic async_in,
	output logic      sync_out,
	output logic      rise,
	output logic      fall
);

	logic [SYNC_STAGES-1:0] stage;
	logic                   next_sync_out;

	always_comb begin
		next_sync_out = sync_out;
		if (stage[1] == stage[2]) begin
			next_sync_out = stage[2];
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			stage    <= {SYNC_STAGES{RESET_VALUE}};
			sync_out <= RESET_VALUE;
		end else begin
			stage    <= {stage[SYNC_STAGES-2:0], async_in};
			sync_out <= next_sync_out;
		end
	end

	assign rise = next_sync_out & ~sync_out;
	assign fall = ~next_sync_out & sync_out;

endmodule

//--- goc_period.sv
`timescale 1ns/1ps
module goc_period
	import goc_pkg::*;
#(
	parameter int TB_SHORT = TB_SHORT_CYC,
	parameter int TB_LONG  = TB_LONG_CYC
)(
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic       run,
	input  wire logic [7:0] period_ctrl,
	output logic            tick
);

	logic [24:0] base_count;
	logic [6:0]  mult_count;
	logic [24:0] next_base_count;
	logic [6:0]  next_mult_count;
	logic        next_tick;
	logic [24:0] base_last;

	always_comb begin
		base_last       = period_ctrl[SP_TIME_BASE_BIT] ? 25'(TB_LONG - 1) : 25'(TB_SHORT - 1);
		next_base_count = base_count;
		next_mult_count = mult_count;
		next_tick       = 1'b0;
		if (!run) begin
			next_base_count = '0;
			next_mult_count = '0;
		end else if (base_count >= base_last) begin
			next_base_count = '0;
			if (mult_count >= period_ctrl[6:0]) begin
				next_mult_count = '0;
				next_tick       = 1'b1;
			end else begin
				next_mult_count = mult_count + 7'h01;
			end
		end else begin
			next_base_count = base_count + 25'h0000001;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			base_count <= '0;
			mult_count <= '0;
			tick       <= 1'b0;
		end else begin
			base_count <= next_base_count;
			mult_count <= next_mult_count;
			tick       <= next_tick;
		end
	end

endmodule

//--- goc_top.sv
`timescale 1ns/1ps
module goc_top
	import goc_pkg::*;
#(
	parameter int TB_SHORT   = TB_SHORT_CYC,
	parameter int TB_LONG    = TB_LONG_CYC,
	parameter int SLEEP_UNIT = SLEEP_UNIT_CYC
)(
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        cs_b,
	input  wire logic        sclk,
	input  wire logic        mosi,
	output logic             miso,
	input  wire logic [1:0]  io_in,
	output logic [1:0]       io_out,
	output logic [1:0]       io_oe,
	input  wire logic        drdy_enable,
	input  wire logic        drdy_line_sel,
	input  wire logic        drdy_active_high,
	input  wire logic [1:0]  alarm_claim,
	input  wire logic [1:0]  alarm_level,
	input  wire logic [15:0] nv_sample_period,
	input  wire logic [15:0] nv_range_and_filter,
	input  wire logic        nv_valid,
	input  wire logic [15:0] sample_data,
	output logic [15:0]      filtered_data,
	output logic             data_update,
	output logic [11:0]      dac_code,
	output logic             low_power,
	output logic             shutdown,
	output logic [2:0]       range_sel,
	output logic [15:0]      sample_period_nv,
	output logic [15:0]      range_and_filter_nv
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic cs_s, cs_rise, cs_fall, sclk_s, sclk_rise, sclk_fall, mosi_s;
	logic [1:0] io_s;

	goc_sync #(.RESET_VALUE(1'b1)) u_cs (.clock(clock), .rst_b(rst_b), .async_in(cs_b),
		.sync_out(cs_s), .rise(cs_rise), .fall(cs_fall));
	goc_sync #(.RESET_VALUE(1'b1)) u_sclk (.clock(clock), .rst_b(rst_b), .async_in(sclk),
		.sync_out(sclk_s), .rise(sclk_rise), .fall(sclk_fall));
	goc_sync #(.RESET_VALUE(1'b0)) u_mosi (.clock(clock), .rst_b(rst_b), .async_in(mosi),
		.sync_out(mosi_s), .rise(), .fall());

	generate
		for (genvar g = 0; g < 2; g++) begin : g_io
			goc_sync #(.RESET_VALUE(1'b0)) u_io (.clock(clock), .rst_b(rst_b),
				.async_in(io_in[g]), .sync_out(io_s[g]), .rise(), .fall());
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Register helpers

	function automatic logic [15:0] reg_mask(input logic [6:0] a);
		if (a == ADDR_AUX_DAC_LEVEL) begin
			reg_mask = MASK_AUX_DAC_LEVEL;
		end else if (a == ADDR_IO_LINE_CONTROL) begin
			reg_mask = MASK_IO_LINE_CONTROL;
		end else if (a == ADDR_SAMPLE_PERIOD) begin
			reg_mask = MASK_SAMPLE_PERIOD;
		end else if (a == ADDR_RANGE_AND_FILTER) begin
			reg_mask = MASK_RANGE_AND_FILTER;
		end else if (a == ADDR_SLEEP_COUNT) begin
			reg_mask = MASK_SLEEP_COUNT;
		end else begin
			reg_mask = 16'h0000;
		end
	endfunction

	// Clamp the tap exponent to the range's minimum
	function automatic logic [3:0] clamp_taps(input logic [2:0] rng, input logic [3:0] m);
		logic [3:0] lim;
		lim = (m > MAX_TAP_EXP) ? MAX_TAP_EXP : m;
		if (rng == RANGE_20 && lim < MIN_TAPS_20) begin
			lim = MIN_TAPS_20;
		end else if (rng == RANGE_40 && lim < MIN_TAPS_40) begin
			lim = MIN_TAPS_40;
		end
		clamp_taps = lim;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Serial slave: 16-bit frames, bit 15 write, bits 14:8 address, 7:0 data

	goc_spi_state_e    spi_state, next_spi_state;
	logic [15:0]       shift_in, next_shift_in;
	logic [15:0]       shift_out, next_shift_out;
	logic [4:0]        bit_count, next_bit_count;
	logic [6:0]        read_addr, next_read_addr;
	logic [15:0]       aux_dac_level, next_aux_dac_level;
	logic [15:0]       io_line_control, next_io_line_control;
	logic [15:0]       sample_period_control, next_sample_period_control;
	logic [15:0]       range_and_filter, next_range_and_filter;
	logic [15:0]       sleep_count, next_sleep_count;
	logic [11:0]       next_dac_code;
	logic              sleep_start, next_sleep_start;
	logic              next_miso;
	logic              loaded, next_loaded;
	logic [15:0]       rd_word;
	logic [15:0]       wr_word;
	logic [6:0]        wr_addr;
	logic              frame_done;

	always_comb begin
		rd_word = 16'h0000;
		if (read_addr[6:1] == ADDR_AUX_DAC_LEVEL[6:1]) begin
			rd_word = aux_dac_level;
		end else if (read_addr[6:1] == ADDR_IO_LINE_CONTROL[6:1]) begin
			rd_word = io_line_control;
			if (io_line_control[1:0] == 2'b00) begin
				rd_word[1:0] = io_s;
			end
		end else if (read_addr[6:1] == ADDR_SAMPLE_PERIOD[6:1]) begin
			rd_word = sample_period_control;
		end else if (read_addr[6:1] == ADDR_RANGE_AND_FILTER[6:1]) begin
			rd_word = range_and_filter;
		end else if (read_addr[6:1] == ADDR_SLEEP_COUNT[6:1]) begin
			rd_word = sleep_count;
		end
	end

	always_comb begin
		next_spi_state = spi_state;
		next_shift_in  = shift_in;
		next_shift_out = shift_out;
		next_bit_count = bit_count;
		next_read_addr = read_addr;
		next_miso      = miso;
		next_aux_dac_level         = aux_dac_level;
		next_io_line_control       = io_line_control;
		next_sample_period_control = sample_period_control;
		next_range_and_filter      = range_and_filter;
		next_sleep_count           = sleep_count;
		next_dac_code    = dac_code;
		// Sleep request waits until chip select is back high
		next_sleep_start = sleep_start && !cs_s;
		next_loaded      = loaded;
		frame_done = 1'b0;
		wr_addr    = {shift_in[13:8], 1'b0} | {6'h00, shift_in[8]};
		wr_word    = 16'h0000;
		if (!loaded && nv_valid) begin
			next_sample_period_control = nv_sample_period & MASK_SAMPLE_PERIOD;
			next_range_and_filter      = nv_range_and_filter & MASK_RANGE_AND_FILTER;
			next_loaded = 1'b1;
		end
		case (spi_state)
			GOC_IDLE: begin
				if (cs_fall) begin
					next_spi_state = GOC_ADDR;
					next_bit_count = '0;
					next_shift_out = rd_word;
					next_miso      = rd_word[15];
				end
			end
			GOC_ADDR, GOC_DATA: begin
				if (cs_rise) begin
					next_spi_state = GOC_IDLE;
				end else if (sclk_rise) begin
					next_shift_in  = {shift_in[14:0], mosi_s};
					next_bit_count = bit_count + 5'h01;
					frame_done     = (bit_count == 5'h0F);
				end else if (sclk_fall) begin
					next_shift_out = {shift_out[14:0], 1'b0};
					next_miso      = shift_out[15];
				end
				if (frame_done) begin
					next_bit_count = '0;
					next_spi_state = GOC_DATA;
					wr_addr = next_shift_in[14:8];
					if (next_shift_in[15]) begin
						wr_word = reg_mask({wr_addr[6:1], 1'b0});
						if (wr_addr[0]) begin
							wr_word = {wr_word[15:8] & next_shift_in[7:0], 8'h00};
						end else begin
							wr_word = {8'h00, wr_word[7:0] & next_shift_in[7:0]};
						end
						if (wr_addr[6:1] == ADDR_AUX_DAC_LEVEL[6:1]) begin
							next_aux_dac_level = wr_addr[0] ? {wr_word[15:8], aux_dac_level[7:0]}
								: {aux_dac_level[15:8], wr_word[7:0]};
						end else if (wr_addr[6:1] == ADDR_IO_LINE_CONTROL[6:1]) begin
							next_io_line_control = wr_addr[0]
								? {wr_word[15:8], io_line_control[7:0]}
								: {io_line_control[15:8], wr_word[7:0]};
						end else if (wr_addr[6:1] == ADDR_SAMPLE_PERIOD[6:1]) begin
							next_sample_period_control = wr_addr[0]
								? {wr_word[15:8], sample_period_control[7:0]}
								: {sample_period_control[15:8], wr_word[7:0]};
						end else if (wr_addr[6:1] == ADDR_RANGE_AND_FILTER[6:1]) begin
							next_range_and_filter = wr_addr[0]
								? {wr_word[15:8], range_and_filter[7:0]}
								: {range_and_filter[15:8], wr_word[7:0]};
						end else if (wr_addr[6:1] == ADDR_SLEEP_COUNT[6:1]) begin
							next_sleep_count = wr_addr[0] ? sleep_count
								: {8'h00, wr_word[7:0]};
							next_sleep_start = wr_addr[0] ? sleep_start
								: (wr_word[7:0] != 8'h00);
						end else if (wr_addr == ADDR_COMMAND
								&& next_shift_in[CMD_DAC_LATCH_BIT]) begin
							next_dac_code = aux_dac_level[11:0];
						end
					end else begin
						next_read_addr = wr_addr;
					end
				end
			end
			default: next_spi_state = GOC_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			spi_state <= GOC_IDLE;
			shift_in  <= '0;
			shift_out <= '0;
			bit_count <= '0;
			read_addr <= '0;
			miso      <= 1'b0;
			aux_dac_level         <= RST_AUX_DAC_LEVEL;
			io_line_control       <= RST_IO_LINE_CONTROL;
			sample_period_control <= RST_SAMPLE_PERIOD;
			range_and_filter      <= RST_RANGE_AND_FILTER;
			sleep_count           <= RST_SLEEP_COUNT;
			dac_code    <= 12'h000;
			sleep_start <= 1'b0;
			loaded      <= 1'b0;
		end else begin
			spi_state <= next_spi_state;
			shift_in  <= next_shift_in;
			shift_out <= next_shift_out;
			bit_count <= next_bit_count;
			read_addr <= next_read_addr;
			miso      <= next_miso;
			aux_dac_level         <= next_aux_dac_level;
			io_line_control       <= next_io_line_control;
			sample_period_control <= next_sample_period_control;
			range_and_filter      <= next_range_and_filter;
			sleep_count           <= next_sleep_count;
			dac_code    <= next_dac_code;
			sleep_start <= next_sleep_start;
			loaded      <= next_loaded;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power management

	goc_power_state_e power_state, next_power_state;
	logic [31:0]      sleep_cycles, next_sleep_cycles;
	logic [7:0]       sleep_left, next_sleep_left;
	logic             next_shutdown, next_low_power;
	logic             tick;

	always_comb begin
		next_power_state  = power_state;
		next_sleep_cycles = sleep_cycles;
		next_sleep_left   = sleep_left;
		case (power_state)
			GOC_RUN: begin
				if (sleep_start && cs_s) begin
					next_power_state  = GOC_SLEEP;
					next_sleep_left   = sleep_count[7:0];
					next_sleep_cycles = '0;
				end
			end
			GOC_SLEEP: begin
				if (!cs_s) begin
					next_power_state = GOC_RUN;
				end else if (sleep_cycles >= 32'(SLEEP_UNIT - 1)) begin
					next_sleep_cycles = '0;
					next_sleep_left   = sleep_left - 8'h01;
					if (sleep_left <= 8'h01) begin
						next_power_state = GOC_RUN;
					end
				end else begin
					next_sleep_cycles = sleep_cycles + 32'h00000001;
				end
			end
			default: next_power_state = GOC_RUN;
		endcase
		next_shutdown  = (next_power_state == GOC_SLEEP);
		// Period above 15.624 ms means rate below 64 SPS
		next_low_power = sample_period_control[SP_TIME_BASE_BIT]
			|| (sample_period_control[6:0] > 7'h07);
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			power_state  <= GOC_RUN;
			sleep_cycles <= '0;
			sleep_left   <= '0;
			shutdown     <= 1'b0;
			low_power    <= 1'b0;
		end else begin
			power_state  <= next_power_state;
			sleep_cycles <= next_sleep_cycles;
			sleep_left   <= next_sleep_left;
			shutdown     <= next_shutdown;
			low_power    <= next_low_power;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sample clock and averaging filter

	goc_period #(.TB_SHORT(TB_SHORT), .TB_LONG(TB_LONG)) u_period (
		.clock(clock), .rst_b(rst_b), .run(power_state == GOC_RUN),
		.period_ctrl(sample_period_control[7:0]), .tick(tick));

	logic [15:0] taps [0:255];
	logic [15:0] next_filtered_data;
	logic [31:0] acc;
	logic [3:0]  m_eff;
	logic [8:0]  n_taps;
	logic [15:0] weight;

	// Bartlett window: box average applied twice over the tap history
	always_comb begin
		m_eff  = clamp_taps(range_and_filter[10:8], range_and_filter[3:0]);
		n_taps = 9'(9'h001 << m_eff);
		acc    = 32'h00000000;
		for (int k = 0; k < 255; k++) begin
			weight = (k < int'(n_taps)) ? 16'(k + 1) : 16'((2 * int'(n_taps)) - 1 - k);
			if (k < 2 * int'(n_taps) - 1) begin
				acc = acc + 32'(taps[k]) * 32'(weight);
			end
		end
		next_filtered_data = 16'(acc >> (2 * m_eff));
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int k = 0; k < 256; k++) begin
				taps[k] <= 16'h0000;
			end
			filtered_data <= 16'h0000;
			data_update   <= 1'b0;
			range_sel     <= RANGE_80;
		end else begin
			if (tick) begin
				taps[0] <= sample_data;
				for (int k = 1; k < 256; k++) begin
					taps[k] <= taps[k-1];
				end
				filtered_data <= next_filtered_data;
			end
			data_update <= tick;
			range_sel   <= range_and_filter[10:8];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// I/O line drivers and nonvolatile image

	logic [1:0] next_io_out, next_io_oe;

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			if (drdy_enable && (drdy_line_sel == 1'(i))) begin
				next_io_oe[i]  = 1'b1;
				next_io_out[i] = data_update ? drdy_active_high : ~drdy_active_high;
			end else if (alarm_claim[i]) begin
				next_io_oe[i]  = 1'b1;
				next_io_out[i] = alarm_level[i];
			end else begin
				next_io_oe[i]  = io_line_control[i];
				next_io_out[i] = io_line_control[IO_LEVEL_LSB + i];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			io_out <= 2'b00;
			io_oe  <= 2'b00;
			sample_period_nv    <= RST_SAMPLE_PERIOD;
			range_and_filter_nv <= RST_RANGE_AND_FILTER;
		end else begin
			io_out <= next_io_out;
			io_oe  <= next_io_oe;
			sample_period_nv    <= sample_period_control;
			range_and_filter_nv <= range_and_filter;
		end
	end

endmodule

//--- goc_monitor.sv
`timescale 1ns/1ps
module goc_monitor
	import goc_pkg::*;
#(
	parameter int TB_SHORT   = TB_SHORT_CYC,
	parameter int TB_LONG    = TB_LONG_CYC,
	parameter int SLEEP_UNIT = SLEEP_UNIT_CYC
)(
	input wire logic        clock,
	input wire logic        rst_b,
	input wire logic        cs_b,
	input wire logic [1:0]  io_out,
	input wire logic [1:0]  io_oe,
	input wire logic        drdy_enable,
	input wire logic        drdy_line_sel,
	input wire logic [1:0]  alarm_claim,
	input wire logic [1:0]  alarm_level,
	input wire logic        data_update,
	input wire logic [11:0] dac_code,
	input wire logic        low_power,
	input wire logic        shutdown,
	input wire logic [2:0]  range_sel,
	input wire logic [15:0] sample_period_nv,
	input wire logic [15:0] range_and_filter_nv
);
	logic [31:0] gap;
	logic [31:0] since_cs;
	logic [31:0] asleep;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////
	// Cycle counters
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			gap      <= 32'h0;
			since_cs <= 32'h0;
			asleep   <= 32'h0;
		end else begin
			gap      <= data_update ? 32'h0 : gap + 32'h1;
			since_cs <= cs_b ? since_cs + 32'h1 : 32'h0;
			asleep   <= shutdown ? asleep + 32'h1 : 32'h0;
		end
	end
	////////////////////////////////////////
	sequence s_cs_low;
		!cs_b [*8];
	endsequence
	sequence s_drdy2;
		(drdy_enable && drdy_line_sel) [*6];
	endsequence
	sequence s_alarm1;
		(alarm_claim[0] && !(drdy_enable && !drdy_line_sel) && $stable(alarm_level)) [*6];
	endsequence
	AST_UPDATE_GAP: assert property (data_update |-> gap >= TB_SHORT - 1)
		else $error("data update too soon");
	AST_UPDATE_PULSE: assert property (data_update |=> !data_update)
		else $error("data update longer than one cycle");
	AST_SLEEP_BOUND: assert property (asleep <= 255 * SLEEP_UNIT + 16)
		else $error("shutdown outlasts the longest count");
	AST_CS_WAKE: assert property (s_cs_low |-> !shutdown)
		else $error("chip select low did not wake");
	AST_DAC_LATCH: assert property ($changed(dac_code) |-> since_cs <= 32'h10)
		else $error("dac output moved outside a frame");
	AST_DRDY_FIRST: assert property (s_drdy2 |-> io_oe[1])
		else $error("data ready line not driven");
	AST_ALARM_OVER_IO: assert property (s_alarm1 |-> io_oe[0] && io_out[0] == alarm_level[0])
		else $error("alarm claim lost to io control");
	AST_LOW_RATE: assert property ((!shutdown && $stable(sample_period_nv)) [*6] |->
		low_power == (sample_period_nv[7] || sample_period_nv[6:0] > 7'h07))
		else $error("low power mode wrong for period");
	AST_RANGE_SEL: assert property ($stable(range_and_filter_nv) [*6] |->
		range_sel == range_and_filter_nv[10:8])
		else $error("range select differs from register");
	AST_UNUSED_ZERO: assert property (sample_period_nv[15:8] == 8'h00 &&
		range_and_filter_nv[15:11] == 5'h00 && range_and_filter_nv[7:4] == 4'h0)
		else $error("unused bits set");
endmodule

bind goc_top goc_monitor #(.TB_SHORT(TB_SHORT), .TB_LONG(TB_LONG), .SLEEP_UNIT(SLEEP_UNIT)) mon (
	.clock, .rst_b, .cs_b, .io_out, .io_oe, .drdy_enable, .drdy_line_sel, .alarm_claim,
	.alarm_level, .data_update, .dac_code, .low_power, .shutdown, .range_sel,
	.sample_period_nv, .range_and_filter_nv);

//--- goc_host.sv
`timescale 1ns/1ps
module goc_host(
	input  wire logic clock,
	output logic      cs_b,
	output logic      sclk,
	output logic      mosi,
	input  wire logic miso
);
	initial begin
		cs_b = 1'b1;
		sclk = 1'b1;
		mosi = 1'b1;
	end
	// Half period in clocks: 50 is 2.5 MHz, 125 is 1 MHz
	task automatic xfer(input logic [15:0] tx, input int hp, output logic [15:0] rx);
		@(posedge clock);
		cs_b <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			repeat (hp) @(posedge clock);
			sclk <= 1'b0;
			mosi <= tx[i];
			repeat (hp) @(posedge clock);
			rx[i] = miso;
			sclk <= 1'b1;
		end
		repeat (8) @(posedge clock);
		cs_b <= 1'b1;
		mosi <= ~tx[0];
		repeat (16) @(posedge clock);
	endtask
	task automatic wake(input int n);
		@(posedge clock);
		cs_b <= 1'b0;
		repeat (n) @(posedge clock);
		cs_b <= 1'b1;
		repeat (16) @(posedge clock);
	endtask
endmodule

//--- gyro_operational_control_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module gyro_operational_control_tb
	import goc_pkg::*;
;
	localparam int TS = 20;
	localparam int TL = 40;
	localparam int SU = 50;
	logic        clock, rst_b, cs_b, sclk, mosi, miso;
	logic [1:0]  io_in, io_out, io_oe, alarm_claim, alarm_level;
	logic        drdy_enable, drdy_line_sel, drdy_active_high, nv_valid;
	logic        data_update, low_power, shutdown;
	logic [15:0] sample_data, filtered_data, rv, spnv, rfnv;
	logic [11:0] dac_code;
	logic [2:0]  range_sel;
	int          err_total, n_compared, hp, cyc;

	goc_top #(.TB_SHORT(TS), .TB_LONG(TL), .SLEEP_UNIT(SU)) uut (.clock, .rst_b, .cs_b, .sclk,
		.mosi, .miso, .io_in, .io_out, .io_oe, .drdy_enable, .drdy_line_sel, .drdy_active_high,
		.alarm_claim, .alarm_level, .nv_sample_period(16'hFF85), .nv_range_and_filter(16'hF20C),
		.nv_valid(nv_valid), .sample_data, .filtered_data, .data_update, .dac_code, .low_power,
		.shutdown, .range_sel, .sample_period_nv(spnv), .range_and_filter_nv(rfnv));
	goc_host host (.clock, .cs_b, .sclk, .mosi, .miso);

	always #2 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 100000) begin
			err_total++;
			report_and_stop;
		end
	end
	////////////////////////////////////////
	task automatic report_and_stop;
		$display("compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wb(input logic [6:0] a, input logic [7:0] d);
		host.xfer({1'b1, a, d}, hp, rv);
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		wb(a + 7'h01, d[15:8]);
		wb(a, d[7:0]);
	endtask
	task automatic rchk(input logic [6:0] a, input logic [15:0] e);
		host.xfer({1'b0, a, 8'h00}, hp, rv);
		host.xfer({1'b0, a, 8'h00}, hp, rv);
		`CHK(rv, e)
	endtask
	task automatic upd(output int n);
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (data_update !== 1'b1);
	endtask
	////////////////////////////////////////
	task automatic t_reset;
		rchk(7'h30, 16'h0000);
		rchk(7'h32, 16'h0000);
		rchk(7'h36, 16'h0001);
		rchk(7'h38, 16'h0402);
		`CHK({range_sel, io_oe, dac_code}, 17'h10000)
	endtask
	task automatic t_fields;
		wr(7'h36, 16'hFF03);
		rchk(7'h36, 16'h0003);
		wr(7'h38, 16'hF10F);
		rchk(7'h38, 16'h010F);
		`CHK(range_sel, 3'h1)
		wb(7'h39, 8'h04);
		`CHK(range_sel, 3'h4)
		wb(7'h3B, 8'hFF);
		rchk(7'h3A, 16'h0000);
		rchk(7'h20, 16'h0000);
	endtask
	task automatic t_period(input logic [15:0] v, input int e, input logic lp);
		int n;
		wr(7'h36, v);
		hp = lp ? 125 : 50;
		upd(n);
		upd(n);
		`CHK(n, e)
		`CHK(low_power, lp)
	endtask
	task automatic t_dac;
		wr(7'h30, 16'hF234);
		`CHK(dac_code, 12'h000)
		rchk(7'h30, 16'h0234);
		wb(7'h3E, 8'h04);
		`CHK(dac_code, 12'h234)
	endtask
	task automatic t_io;
		wr(7'h32, 16'h0202);
		`CHK({io_oe, io_out[1]}, 3'b101)
		wr(7'h32, 16'h0000);
		@(posedge clock) io_in <= 2'b10;
		rchk(7'h32, 16'h0002);
		wr(7'h32, 16'h0101);
		@(posedge clock) begin
			alarm_claim <= 2'b01;
			drdy_enable <= 1'b1;
			drdy_line_sel <= 1'b1;
		end
		repeat (10) @(posedge clock);
		`CHK({io_oe, io_out[0]}, 3'b110)
		@(posedge clock) begin
			alarm_claim <= 2'b00;
			drdy_enable <= 1'b0;
		end
		repeat (10) @(posedge clock);
		`CHK({io_oe, io_out[0]}, 3'b011)
		`CHK(filtered_data, 16'h1234)
	endtask
	task automatic t_sleep;
		wb(7'h3A, 8'h03);
		repeat (3 * SU - 40) @(posedge clock);
		`CHK(shutdown, 1'b1)
		repeat (60) @(posedge clock);
		`CHK(shutdown, 1'b0)
		wb(7'h3A, 8'h10);
		`CHK(shutdown, 1'b1)
		host.wake(10);
		`CHK(shutdown, 1'b0)
		wb(7'h3A, 8'h00);
		`CHK(shutdown, 1'b0)
	endtask
	task automatic t_nv;
		@(posedge clock) rst_b <= 1'b0;
		@(posedge clock) begin
			rst_b <= 1'b1;
			nv_valid <= 1'b1;
		end
		repeat (4) @(posedge clock);
		`CHK({spnv, rfnv}, 32'h0085020C)
		`CHK(dac_code, 12'h000)
	endtask
	////////////////////////////////////////
	initial begin
		clock = 1'b0;
		rst_b = 1'b0;
		io_in = 2'b00;
		alarm_claim = 2'b00;
		alarm_level = 2'b00;
		drdy_enable = 1'b0;
		drdy_line_sel = 1'b0;
		drdy_active_high = 1'b1;
		sample_data = 16'h1234;
		err_total = 0;
		n_compared = 0;
		hp = 50;
		nv_valid = 1'b0;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		repeat (4) @(posedge clock);
		t_reset;
		t_fields;
		t_period(16'h0080, TL, 1'b1);
		t_period(16'h0008, 9 * TS, 1'b1);
		t_period(16'h0007, 8 * TS, 1'b0);
		t_period(16'h0001, 2 * TS, 1'b0);
		t_dac;
		t_io;
		t_sleep;
		t_nv;
		report_and_stop;
	end
endmodule
